// File: hdl/standby_device.sv
// device end: standby sequencing, register slave, pixel port
`timescale 1ns/1ps
`default_nettype none
module standby_device #(
    parameter int FRAME_CYCLES = standby_pkg::FRAME_CYCLES
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    standby_if.device link,
    output logic      mcu_irq,
    output logic      hard_active,
    output logic      soft_active,
    output logic      slave_active,
    output logic      pipe_active
);
    typedef enum logic [2:0] {
        ST_RUN, ST_HS_ENTER, ST_HARD, ST_DEAD, ST_SS_ENTER, ST_SOFT, ST_SS_EXIT
    } dev_state_t;

    localparam logic [15:0] ENTRY_LAST = 16'(FRAME_CYCLES + standby_pkg::ENTRY_EXTRA - 1);
    localparam logic [15:0] EXIT_LAST  = 16'(standby_pkg::CLK_GUARD - 1);
    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
    localparam logic [15:0] FRAME_END  = 16'((FRAME_CYCLES * 3) / 4);

    if (FRAME_CYCLES < 16 || FRAME_CYCLES + standby_pkg::HOLD_EXTRA > 65535) begin : g_chk
        $error("FRAME_CYCLES out of range");
    end

    dev_state_t  state_q;
    dev_state_t  state_d;
    logic [15:0] cnt_q;
    logic        rst;
    logic        req_q;
    logic        en_q;
    logic        retain_q;
    logic        sdrive_q;
    logic        oe_pin_en_q;
    logic        par_en_q;
    logic        ack_q;
    logic [15:0] rdata_q;
    logic        irq_q;
    logic [15:0] pix_q;
    logic        pclk_q;
    logic        line_q;
    logic        frame_q;
    logic [7:0]  dout_q;
    logic        clk_live;
    logic        hard_zone;
    logic        slave_on;
    logic        take;
    logic        wr_sys;
    logic        wr_out;
    logic        soft_status;
    logic        pipe_run;
    logic        drive;
    logic [15:0] sys_rd;
    logic [15:0] out_rd;

    // host reset pin and system reset both clear the device
    assign rst = !aresetn || !link.reset_n;

    // internal clock gated in hard standby, or stopped by host
    assign clk_live  = link.ref_clk_run && !(state_q inside {ST_HARD, ST_DEAD});
    assign hard_zone = link.standby || (state_q inside {ST_HS_ENTER, ST_HARD, ST_DEAD});
    assign slave_on  = clk_live && !hard_zone;
    assign take      = link.req && !ack_q && slave_on;
    assign wr_sys    = take && link.we && (link.addr == standby_pkg::SYS_CTRL_ADDR);
    assign wr_out    = take && link.we && (link.addr == standby_pkg::OUTCTL_ADDR);
    assign soft_status = state_q inside {ST_SOFT, ST_SS_EXIT};
    assign pipe_run  = (state_q == ST_RUN) && clk_live && !link.standby;

    // standby sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (link.standby) begin
                    state_d = ST_HS_ENTER;
                end else if (req_q && en_q) begin
                    state_d = ST_SS_ENTER;
                end
            end
            ST_HS_ENTER: begin
                if (clk_live && cnt_q == ENTRY_LAST) begin
                    state_d = ST_HARD;
                end
            end
            ST_HARD: begin
                if (!link.standby) begin
                    state_d = retain_q ? ST_RUN : ST_DEAD;
                end
            end
            ST_DEAD: begin
                state_d = ST_DEAD; // left only through reset
            end
            ST_SS_ENTER: begin
                if (clk_live && cnt_q == ENTRY_LAST) begin
                    state_d = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (link.standby) begin
                    state_d = ST_HS_ENTER;
                end else if (!req_q) begin
                    state_d = ST_SS_EXIT;
                end
            end
            ST_SS_EXIT: begin
                if (clk_live && cnt_q == EXIT_LAST) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge aclk) begin
        if (rst) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // cycle counter, restarts on every state change
    always_ff @(posedge aclk) begin
        if (rst || state_d != state_q) begin
            cnt_q <= 16'h0000;
        end else if (clk_live) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // system control register, kept through soft standby
    always_ff @(posedge aclk) begin
        if (rst) begin
            req_q    <= standby_pkg::SYS_CTRL_RESET[standby_pkg::REQ_BIT];
            en_q     <= standby_pkg::SYS_CTRL_RESET[standby_pkg::EN_BIT];
            retain_q <= standby_pkg::SYS_CTRL_RESET[standby_pkg::RETAIN_BIT];
            sdrive_q <= standby_pkg::SYS_CTRL_RESET[standby_pkg::SDRIVE_BIT];
        end else if (wr_sys) begin
            req_q    <= link.wdata[standby_pkg::REQ_BIT];
            en_q     <= link.wdata[standby_pkg::EN_BIT];
            retain_q <= link.wdata[standby_pkg::RETAIN_BIT];
            sdrive_q <= link.wdata[standby_pkg::SDRIVE_BIT];
        end
    end

    // output control register
    always_ff @(posedge aclk) begin
        if (rst) begin
            oe_pin_en_q <= standby_pkg::OUTCTL_RESET[standby_pkg::OE_PIN_BIT];
            par_en_q    <= standby_pkg::OUTCTL_RESET[standby_pkg::PAR_EN_BIT];
        end else if (wr_out) begin
            oe_pin_en_q <= link.wdata[standby_pkg::OE_PIN_BIT];
            par_en_q    <= link.wdata[standby_pkg::PAR_EN_BIT];
        end
    end

    // read views, reserved bits zero
    always_comb begin
        sys_rd = 16'h0000;
        sys_rd[standby_pkg::REQ_BIT]    = req_q;
        sys_rd[standby_pkg::EN_BIT]     = en_q;
        sys_rd[standby_pkg::RETAIN_BIT] = retain_q;
        sys_rd[standby_pkg::SDRIVE_BIT] = sdrive_q;
        sys_rd[standby_pkg::STAT_BIT]   = soft_status;
        out_rd = 16'h0000;
        out_rd[standby_pkg::OE_PIN_BIT] = oe_pin_en_q;
        out_rd[standby_pkg::PAR_EN_BIT] = par_en_q;
    end

    // register slave answer, one cycle after take
    always_ff @(posedge aclk) begin
        if (rst) begin
            ack_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= take;
            if (take) begin
                if (link.addr == standby_pkg::SYS_CTRL_ADDR) begin
                    rdata_q <= sys_rd;
                end else if (link.addr == standby_pkg::OUTCTL_ADDR) begin
                    rdata_q <= out_rd;
                end else begin
                    rdata_q <= 16'h0000;
                end
            end
        end
    end

    // microcontroller interrupt on request write with enable set
    always_ff @(posedge aclk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= wr_sys && en_q && link.wdata[standby_pkg::REQ_BIT];
        end
    end

    // pixel pipeline, frozen outside normal run
    always_ff @(posedge aclk) begin
        if (rst) begin
            pix_q  <= 16'h0000;
            pclk_q  <= 1'b0;
            frame_q <= 1'b0;
            line_q  <= 1'b0;
            dout_q  <= 8'h00;
        end else if (pipe_run) begin
            pix_q   <= (pix_q == FRAME_LAST) ? 16'h0000 : pix_q + 16'h0001;
            pclk_q  <= !pclk_q;
            frame_q <= pix_q < FRAME_END;
            line_q  <= (pix_q < FRAME_END) && pix_q[3];
            dout_q <= pix_q[7:0];
        end
    end

    // parallel drive: combinational from the enable pin, no clock in path
    always_comb begin
        drive = 1'b0;
        if (!rst && par_en_q && !(oe_pin_en_q && link.oe_pin_n)) begin
            if (state_q == ST_RUN) begin
                drive = 1'b1;
            end else if (state_q == ST_SOFT) begin
                drive = sdrive_q || (oe_pin_en_q && !link.oe_pin_n);
            end
        end
    end

    // pads
    assign link.par_oe    = drive;
    assign link.dout      = dout_q;
    assign link.pixel_out_clock = pclk_q;
    assign link.line_valid_out  = line_q;
    assign link.frame_valid_out = frame_q;
    assign link.ser_lanes = 4'h0;
    assign link.ser_oe    = 1'b1;
    assign link.ack       = ack_q;
    assign link.rdata     = rdata_q;

    // user-side status
    assign mcu_irq      = irq_q;
    assign hard_active  = state_q inside {ST_HARD, ST_DEAD};
    assign soft_active  = soft_status;
    assign slave_active = slave_on;
    assign pipe_active  = pipe_run;
endmodule : standby_device
`default_nettype wire

// File: hdl/standby_host.sv
// host end: standby sequencer with AXI4-Lite control registers
`timescale 1ns/1ps
`default_nettype none
module standby_host #(
    parameter int FRAME_CYCLES = standby_pkg::FRAME_CYCLES,
    parameter int BOOT_CYCLES  = standby_pkg::BOOT_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    standby_if.host          link
);
    typedef enum logic [3:0] {
        H_IDLE, H_OUTWR, H_RETWR, H_HHOLD, H_HWAIT, H_HGUARD, H_RST, H_BOOT,
        H_SEN, H_SWR, H_SPOLL1, H_SHOLD, H_SWAIT, H_SCLR, H_SPOLL0
    } host_state_t;

    localparam logic [15:0] HOLD_LAST  = 16'(FRAME_CYCLES + standby_pkg::HOLD_EXTRA - 1);
    localparam logic [15:0] GUARD_LAST = 16'(standby_pkg::CLK_GUARD - 1);
    localparam logic [15:0] RST_LAST   = 16'(standby_pkg::RESET_PULSE - 1);
    localparam logic [15:0] BOOT_LAST  = 16'(BOOT_CYCLES - 1);

    if (FRAME_CYCLES < 16 || FRAME_CYCLES + standby_pkg::HOLD_EXTRA > 65535 ||
        BOOT_CYCLES < 1 || BOOT_CYCLES > 65535) begin : g_chk
        $error("cycle counts out of range");
    end

    host_state_t state_q;
    host_state_t state_d;
    logic [15:0] cnt_q;
    logic [6:0]  ctrl_q;
    logic        dirty_q;
    logic        seen_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wr_do;
    logic        ack;
    logic        stat;
    logic [31:0] stat_rd;
    logic [15:0] wr_word;

    assign ack  = link.ack;
    assign stat = link.rdata[standby_pkg::STAT_BIT];
    assign wr_do = aw_got_q && w_got_q;

    // AXI write: address and data in either order, response after both
    assign awready = !aw_got_q && !bvalid_q;
    assign wready  = !w_got_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q  <= standby_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (wr_do) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q == standby_pkg::CTRL_ADDR || awaddr_q == standby_pkg::STAT_ADDR)
                            ? standby_pkg::RESP_OKAY : standby_pkg::RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // control register; a new write beats the clear of the dirty flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q  <= standby_pkg::CTRL_RESET;
            dirty_q <= 1'b0;
        end else begin
            if (wr_do && awaddr_q == standby_pkg::CTRL_ADDR && wstrb_q[0]) begin
                ctrl_q  <= wdata_q[6:0];
                dirty_q <= 1'b1;
            end else if (state_q == H_BOOT && cnt_q == BOOT_LAST) begin
                dirty_q <= 1'b1;
            end else if (state_q == H_OUTWR && ack) begin
                dirty_q <= 1'b0;
            end
        end
    end

    // AXI read
    always_comb begin
        stat_rd = 32'h0000_0000;
        stat_rd[0] = state_q != H_IDLE;
        stat_rd[1] = state_q inside {H_HHOLD, H_HWAIT, H_HGUARD};
        stat_rd[2] = state_q inside {H_SHOLD, H_SWAIT};
        stat_rd[3] = state_q inside {H_RST, H_BOOT};
        stat_rd[4] = seen_q;
    end
    assign arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= standby_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= standby_pkg::RESP_OKAY;
            if ({araddr[7:2], 2'b00} == standby_pkg::CTRL_ADDR) begin
                rdata_q <= {25'h0, ctrl_q};
            end else if ({araddr[7:2], 2'b00} == standby_pkg::STAT_ADDR) begin
                rdata_q <= stat_rd;
            end else begin
                rdata_q <= 32'h0000_0000;
                rresp_q <= standby_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            H_IDLE: begin
                if (dirty_q) begin
                    state_d = H_OUTWR;
                end else if (ctrl_q[standby_pkg::C_HARD]) begin
                    state_d = H_RETWR;
                end else if (ctrl_q[standby_pkg::C_SOFT]) begin
                    state_d = H_SEN;
                end
            end
            H_OUTWR:  if (ack) state_d = H_IDLE;
            H_RETWR:  if (ack) state_d = H_HHOLD;
            H_HHOLD:  if (cnt_q == HOLD_LAST) state_d = H_HWAIT;
            H_HWAIT:  if (!ctrl_q[standby_pkg::C_HARD]) state_d = H_HGUARD;
            H_HGUARD: begin
                if (cnt_q == GUARD_LAST) begin
                    state_d = ctrl_q[standby_pkg::C_RETAIN] ? H_IDLE : H_RST;
                end
            end
            H_RST:    if (cnt_q == RST_LAST) state_d = H_BOOT;
            H_BOOT:   if (cnt_q == BOOT_LAST) state_d = H_IDLE;
            H_SEN:    if (ack) state_d = H_SWR;
            H_SWR:    if (ack) state_d = H_SPOLL1;
            H_SPOLL1: if (ack && stat) state_d = H_SHOLD;
            H_SHOLD:  if (cnt_q == HOLD_LAST) state_d = H_SWAIT;
            H_SWAIT:  if (!ctrl_q[standby_pkg::C_SOFT]) state_d = H_SCLR;
            H_SCLR:   if (ack) state_d = H_SPOLL0;
            H_SPOLL0: if (ack && !stat) state_d = H_IDLE;
            default:  state_d = H_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= H_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_d != state_q) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // last soft standby status read from the device
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_q <= 1'b0;
        end else if (ack && state_q inside {H_SPOLL1, H_SPOLL0}) begin
            seen_q <= stat;
        end
    end

    // register write word per state
    always_comb begin
        wr_word = 16'h0000;
        case (state_q)
            H_OUTWR: begin
                wr_word[standby_pkg::OE_PIN_BIT] = ctrl_q[standby_pkg::C_OE_PIN];
                wr_word[standby_pkg::PAR_EN_BIT] = ctrl_q[standby_pkg::C_PAR_EN];
            end
            H_RETWR: wr_word[standby_pkg::RETAIN_BIT] = ctrl_q[standby_pkg::C_RETAIN];
            H_SEN, H_SWR, H_SCLR: begin
                wr_word[standby_pkg::EN_BIT]     = 1'b1;
                wr_word[standby_pkg::REQ_BIT]    = state_q == H_SWR;
                wr_word[standby_pkg::SDRIVE_BIT] = ctrl_q[standby_pkg::C_SDRIVE];
            end
            default: wr_word = 16'h0000;
        endcase
    end

    // link pins
    assign link.req   = state_q inside {H_OUTWR, H_RETWR, H_SEN, H_SWR, H_SPOLL1, H_SCLR, H_SPOLL0};
    assign link.we    = state_q inside {H_OUTWR, H_RETWR, H_SEN, H_SWR, H_SCLR};
    assign link.addr  = (state_q == H_OUTWR) ? standby_pkg::OUTCTL_ADDR : standby_pkg::SYS_CTRL_ADDR;
    assign link.wdata = wr_word;
    assign link.standby     = state_q inside {H_HHOLD, H_HWAIT, H_HGUARD};
    assign link.ref_clk_run = state_q != H_HWAIT;
    assign link.reset_n     = state_q != H_RST;
    assign link.oe_pin_n    = !ctrl_q[standby_pkg::C_OE_LOW];
endmodule : standby_host
`default_nettype wire

// File: hdl/standby_if.sv
// link between host end and standby device end
`timescale 1ns/1ps
`default_nettype none
interface standby_if;
    logic        standby;
    logic        reset_n;
    logic        ref_clk_run;
    logic        oe_pin_n;
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        ack;
    logic [7:0]  dout;
    logic        pixel_out_clock;
    logic        line_valid_out;
    logic        frame_valid_out;
    logic        par_oe;
    logic [3:0]  ser_lanes;
    logic        ser_oe;
    modport device (
        input  standby, reset_n, ref_clk_run, oe_pin_n, req, we, addr, wdata,
        output rdata, ack, dout, pixel_out_clock, line_valid_out, frame_valid_out, par_oe, ser_lanes, ser_oe
    );
    modport host (
        output standby, reset_n, ref_clk_run, oe_pin_n, req, we, addr, wdata,
        input  rdata, ack, dout, pixel_out_clock, line_valid_out, frame_valid_out, par_oe, ser_lanes, ser_oe
    );
endinterface : standby_if
`default_nettype wire

// File: hdl/standby_pkg.sv
// shared constants for the standby controller, host end and link
package standby_pkg;
    // device register map
    localparam logic [15:0] SYS_CTRL_ADDR = 16'h0018;
    localparam logic [15:0] OUTCTL_ADDR  = 16'h001A;
    localparam int          REQ_BIT      = 0;
    localparam int          EN_BIT       = 3;
    localparam int          RETAIN_BIT   = 4;
    localparam int          SDRIVE_BIT   = 6;
    localparam int          STAT_BIT     = 14;
    localparam int          OE_PIN_BIT   = 8;
    localparam int          PAR_EN_BIT   = 9;
    localparam logic [15:0] SYS_CTRL_RESET = 16'h0000;
    localparam logic [15:0] OUTCTL_RESET = 16'h0000;
    // timing in reference clock cycles
    localparam int          ENTRY_EXTRA  = 40;
    localparam int          HOLD_EXTRA   = 120;
    localparam int          CLK_GUARD    = 10;
    localparam int          RESET_PULSE  = 100;
    localparam int          BOOT_CYCLES  = 6000;
    localparam int          FRAME_CYCLES = 1000;
    // controller register map
    localparam logic [7:0]  CTRL_ADDR    = 8'h00;
    localparam logic [7:0]  STAT_ADDR    = 8'h04;
    localparam int          C_HARD       = 0;
    localparam int          C_SOFT       = 1;
    localparam int          C_RETAIN     = 2;
    localparam int          C_SDRIVE     = 3;
    localparam int          C_OE_LOW     = 4;
    localparam int          C_PAR_EN     = 5;
    localparam int          C_OE_PIN     = 6;
    localparam logic [6:0]  CTRL_RESET   = 7'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : standby_pkg

// File: verification/sensor_standby_control_tb.sv
// bench driving the host registers with both link ends joined
`timescale 1ns/1ps
`default_nettype none
module sensor_standby_control_tb;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic        rvalid, rready, irq, hard_a, soft_a, slave_a, pipe_a;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, q;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    int          fails, n_compared, irqs;
    standby_if link_if();
    standby_device #(.FRAME_CYCLES(16)) standby_device_i(.aclk, .aresetn, .link(link_if), .mcu_irq(irq),
        .hard_active(hard_a), .soft_active(soft_a), .slave_active(slave_a), .pipe_active(pipe_a));
    standby_host #(.FRAME_CYCLES(16), .BOOT_CYCLES(20)) standby_host_i(.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .link(link_if));
    standby_properties #(.FRAME_CYCLES(16)) standby_properties_i(.aclk, .aresetn, .standby(link_if.standby),
        .reset_n(link_if.reset_n), .ref_clk_run(link_if.ref_clk_run), .req(link_if.req), .we(link_if.we),
        .addr(link_if.addr), .wdata(link_if.wdata), .rdata(link_if.rdata), .ack(link_if.ack),
        .par_oe(link_if.par_oe), .ser_lanes(link_if.ser_lanes), .ser_oe(link_if.ser_oe));
    // clock
    always #5 aclk = ~aclk;
    // interrupt pulses seen
    always @(negedge aclk) irqs += irq;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] e);
        logic ta, tw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awready;
            tw = wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(negedge aclk); while (!bvalid);
        e = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        e = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    // status polling and pad-drive waits, both bounded
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 500; i++) begin
            rd(standby_pkg::STAT_ADDR, q, r);
            if ((q & m) == v) break;
        end
        chk(q & m, v);
    endtask : poll
    task automatic oe(input logic e);
        @(negedge aclk);
        for (int i = 0; i < 60 && link_if.par_oe !== e; i++) @(negedge aclk);
        chk({31'h0, link_if.par_oe}, {31'h0, e});
    endtask : oe
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // watchdog
    initial begin
        repeat (30000) @(posedge aclk);
        fails++;
        end_of_test;
    end
    // main sequence
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        fails = 0;
        n_compared = 0;
        irqs = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(standby_pkg::CTRL_ADDR, q, r);
        chk(q, 32'h0);
        oe(1'b0);
        rd(8'h08, q, r);
        chk({30'h0, r}, {30'h0, standby_pkg::RESP_SLVERR});
        wr(8'h20, 32'h1, r);
        chk({30'h0, r}, {30'h0, standby_pkg::RESP_SLVERR});
        $display("test registers done");
        wr(standby_pkg::CTRL_ADDR, 32'h20, r);
        oe(1'b1);
        chk({31'h0, pipe_a}, 32'h1);
        wr(standby_pkg::CTRL_ADDR, 32'h60, r);
        oe(1'b0);
        wr(standby_pkg::CTRL_ADDR, 32'h70, r);
        oe(1'b1);
        $display("test output enable done");
        wr(standby_pkg::CTRL_ADDR, 32'h22, r);
        poll(32'h14, 32'h14);
        oe(1'b0);
        chk({31'h0, soft_a}, 32'h1);
        chk({31'h0, pipe_a}, 32'h0);
        chk(irqs, 32'h1);
        wr(standby_pkg::CTRL_ADDR, 32'h20, r);
        poll(32'h11, 32'h0);
        oe(1'b1);
        wr(standby_pkg::CTRL_ADDR, 32'h2A, r);
        poll(32'h14, 32'h14);
        oe(1'b1);
        wr(standby_pkg::CTRL_ADDR, 32'h20, r);
        poll(32'h11, 32'h0);
        $display("test soft standby done");
        wr(standby_pkg::CTRL_ADDR, 32'h25, r);
        poll(32'h2, 32'h2);
        oe(1'b0);
        chk({31'h0, slave_a}, 32'h0);
        chk({31'h0, pipe_a}, 32'h0);
        repeat (60) @(negedge aclk);
        chk({31'h0, hard_a}, 32'h1);
        wr(standby_pkg::CTRL_ADDR, 32'h20, r);
        poll(32'hB, 32'h0);
        oe(1'b1);
        wr(standby_pkg::CTRL_ADDR, 32'h21, r);
        poll(32'h2, 32'h2);
        wr(standby_pkg::CTRL_ADDR, 32'h20, r);
        poll(32'hB, 32'h0);
        oe(1'b1);
        $display("test hard standby done");
        end_of_test;
    end
endmodule : sensor_standby_control_tb
`default_nettype wire

// File: verification/standby_properties.sv
// link checker for the standby host and device ends
`timescale 1ns/1ps
`default_nettype none
module standby_properties #(
    parameter int FRAME_CYCLES = standby_pkg::FRAME_CYCLES
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        standby,
    input wire logic        reset_n,
    input wire logic        ref_clk_run,
    input wire logic        req,
    input wire logic        we,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic        ack,
    input wire logic        par_oe,
    input wire logic [3:0]  ser_lanes,
    input wire logic        ser_oe
);
    localparam int MIN_SOFT = FRAME_CYCLES + standby_pkg::ENTRY_EXTRA;
    logic [15:0] cnt_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles since the last soft request write
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cnt_q <= 16'h0000;
        else if (ack && we && addr == standby_pkg::SYS_CTRL_ADDR && wdata[standby_pkg::REQ_BIT])
            cnt_q <= 16'h0000;
        else if (cnt_q != 16'hFFFF)
            cnt_q <= cnt_q + 16'h0001;
    end
    // slave handshake, gating and pad states
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (
        req && !ack && ref_clk_run && reset_n && !standby && !$past(standby) |-> ##[1:3] ack)
        else $error("request not answered");
    a_hard_no_ack: assert property (standby |=> !ack)
        else $error("slave answered in hard standby");
    a_stopped_no_ack: assert property (!ref_clk_run |=> !ack)
        else $error("slave answered with clock stopped");
    a_reset_hiz: assert property (!reset_n |=> !par_oe && !ack)
        else $error("outputs driven in reset");
    a_lanes_low: assert property (ser_oe && ser_lanes == 4'h0)
        else $error("serial lanes not driven low");
    a_hard_hiz: assert property (standby |=> !par_oe)
        else $error("parallel port driven in hard standby");
    a_soft_min: assert property (
        ack && !we && addr == standby_pkg::SYS_CTRL_ADDR && rdata[standby_pkg::STAT_BIT] |-> cnt_q >= MIN_SOFT)
        else $error("soft status reported too early");
    c_soft_seen: cover property (ack && !we && rdata[standby_pkg::STAT_BIT]);
    c_hard_seen: cover property (standby ##1 !ref_clk_run);
    c_reset_seen: cover property (!reset_n);
endmodule : standby_properties
`default_nettype wire
